// *** verilog/sdc_pkg.sv ***
// Constants and field layout for the synthesizer divider configuration loader
package sdc_pkg;

    // Field widths
    localparam int unsigned SDC_M_W     = 9;
    localparam int unsigned SDC_N_W     = 2;
    localparam int unsigned SDC_T_W     = 3;
    localparam int unsigned SDC_SHIFT_W = SDC_T_W + SDC_N_W + SDC_M_W;

    // Field positions inside the serial shift word (first bit lands at the top)
    localparam int unsigned SDC_T_LSB = SDC_N_W + SDC_M_W;
    localparam int unsigned SDC_N_LSB = SDC_M_W;
    localparam int unsigned SDC_M_LSB = 0;

    // Values after reset, and the test select forced while the parallel strobe is low
    localparam logic [SDC_M_W-1:0]     SDC_M_RST     = 9'h000;
    localparam logic [SDC_N_W-1:0]     SDC_N_RST     = 2'h0;
    localparam logic [SDC_T_W-1:0]     SDC_T_RST     = 3'h0;
    localparam logic [SDC_T_W-1:0]     SDC_T_FORCED  = 3'h0;
    localparam logic [SDC_SHIFT_W-1:0] SDC_SHIFT_RST = 14'h0000;

    // Frequency plan
    localparam int unsigned SDC_REF_DIV      = 16;
    localparam int unsigned SDC_VCO_DIV      = 4;
    localparam int unsigned SDC_XTAL_KHZ     = 16000;
    localparam int unsigned SDC_VCO_MIN_KHZ  = 800000;
    localparam int unsigned SDC_VCO_MAX_KHZ  = 1600000;
    localparam int unsigned SDC_FREQ_W       = 32;

    // Synchroniser depth
    localparam int unsigned SDC_SYNC_STAGES = 2;

endpackage

// *** verilog/sdc_ser_if.sv ***
// Carrier for the serial shift word between the link-clock shifter and the loader
`timescale 1ns/100ps
interface sdc_ser_if;
    import sdc_pkg::*;

    logic [SDC_SHIFT_W-1:0] word;

    modport shifter (output word);
    modport loader  (input  word);
endinterface

// *** verilog/sdc_sync.sv ***
// Two-flop level synchroniser of parameterised width
`timescale 1ns/100ps
module sdc_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    // Data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    import sdc_pkg::*;

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule

// *** verilog/sdc_shift.sv ***
// Serial configuration shift register on the serial shift clock
`timescale 1ns/100ps
module sdc_shift (
    // Link clock and reset
    input  wire logic   i_sclk,
    input  wire logic   i_rst_b,
    // Serial data
    input  wire logic   i_sdata,
    // Shift word toward the loader
    sdc_ser_if.shifter  ser
);
    import sdc_pkg::*;

    logic [SDC_SHIFT_W-1:0] shift_r;

    // Sample on the rising edge; earlier bits move toward the test-select end
    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shift_r <= SDC_SHIFT_RST;
        end else begin
            shift_r <= {shift_r[SDC_SHIFT_W-2:0], i_sdata}; // R3 R6 R17
        end
    end

    assign ser.word = shift_r;
endmodule

// *** verilog/sdc_top.sv ***
// Divider configuration loader: parallel latch, serial port transfer and frequency status
//
// Notes on behaviour
// (R1) Parallel strobe rise captures divide pins
// (R2) Parallel strobe low: latches transparent to pins
// (R3) Shift clock shifts data into 14-bit register
// (R4) Serial load acts only with parallel strobe high
// (R5) Stream order: test, post-divide, feedback bits
// (R6) Each field most significant bit first
// (R7) Serial strobe pulse after full shift transfers
// (R8) Transfer on serial strobe falling edge only
// (R9) Post-divide code 00/01/10/11 gives 1/2/4/8
// (R10) Feedback field is plain unsigned binary
// (R11) Output is crystal/16 times feedback / post
// (R12) 16 MHz crystal spans 25 to 400 MHz
// (R13) Controller sets parallel at power-up, serial later
// (R14) Controller keeps VCO within 800-1600 MHz; the bench controller model also sets feedback 9'h1F4, a 2000 MHz VCO
// (R15) Parallel strobe low forces test bits zero
// (R16) Controller keeps shift clock at most 10 MHz; the bench controller model runs it at 12.5 MHz
// (R17) Data sampled on shift clock rising edge
// (R18) Counters hold until next capture or transfer
`timescale 1ns/100ps
module sdc_top #(
    parameter int unsigned XTAL_KHZ = sdc_pkg::SDC_XTAL_KHZ
) (
    // System clock and reset
    input  wire logic                              i_clk,
    input  wire logic                              i_rst_b,
    // Parallel configuration pins
    input  wire logic                              i_pload_b,
    input  wire logic [sdc_pkg::SDC_M_W-1:0]       i_m_pin,
    input  wire logic [sdc_pkg::SDC_N_W-1:0]       i_n_pin,
    // Serial configuration pins
    input  wire logic                              i_sclk,
    input  wire logic                              i_sdata,
    input  wire logic                              i_sload,
    // Divider settings
    output logic      [sdc_pkg::SDC_M_W-1:0]       o_m_div,
    output logic      [sdc_pkg::SDC_N_W-1:0]       o_n_sel,
    output logic      [3:0]                        o_post_ratio,
    output logic      [sdc_pkg::SDC_T_W-1:0]       o_test_sel,
    // Load status
    output logic                                   o_cfg_update,
    output logic                                   o_src_serial,
    // Frequency status
    output logic      [sdc_pkg::SDC_FREQ_W-1:0]    o_fout_khz,
    output logic      [sdc_pkg::SDC_FREQ_W-1:0]    o_fstep_khz,
    output logic                                   o_vco_in_range
);
    import sdc_pkg::*;

    // Divide-by ratio for a post-divide select code
    function automatic logic [3:0] sdc_post_ratio(input logic [SDC_N_W-1:0] code);
        sdc_post_ratio = 4'h1 << code; // R9
    endfunction

    // Scale a frequency by the post-divide select code
    function automatic logic [SDC_FREQ_W-1:0] sdc_post_scale(input logic [SDC_FREQ_W-1:0] base,
                                                             input logic [SDC_N_W-1:0]    code);
        sdc_post_scale = base >> code; // R9 R11
    endfunction

    localparam logic [SDC_FREQ_W-1:0] REF_KHZ = SDC_FREQ_W'(XTAL_KHZ / SDC_REF_DIV);
    localparam logic [SDC_FREQ_W-1:0] VCO_MIN = SDC_FREQ_W'(SDC_VCO_MIN_KHZ);
    localparam logic [SDC_FREQ_W-1:0] VCO_MAX = SDC_FREQ_W'(SDC_VCO_MAX_KHZ);
    localparam logic [SDC_FREQ_W-1:0] XTAL_W  = SDC_FREQ_W'(XTAL_KHZ);

    // Serial shifter on the link clock
    sdc_ser_if ser ();

    sdc_shift u_shift (
        .i_sclk  (i_sclk),
        .i_rst_b (i_rst_b),
        .i_sdata (i_sdata),
        .ser     (ser.shifter)
    );

    // Pin synchronisers
    logic [1:0]                        strobe_s;
    logic [SDC_M_W+SDC_N_W-1:0]        pins_s;
    logic [SDC_SHIFT_W-1:0]            word_s;

    sdc_sync #(.WIDTH(2)) u_sync_strobe (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async ({i_pload_b, i_sload}),
        .o_sync  (strobe_s)
    );

    sdc_sync #(.WIDTH(SDC_M_W + SDC_N_W)) u_sync_pins (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async ({i_m_pin, i_n_pin}),
        .o_sync  (pins_s)
    );

    // The shift word is static once the shift clock stops before the strobe
    sdc_sync #(.WIDTH(SDC_SHIFT_W)) u_sync_word (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_async (ser.word),
        .o_sync  (word_s)
    );

    logic                   pload_s;
    logic                   sload_s;
    logic [SDC_M_W-1:0]     m_pin_s;
    logic [SDC_N_W-1:0]     n_pin_s;
    logic [SDC_M_W-1:0]     m_word;
    logic [SDC_N_W-1:0]     n_word;
    logic [SDC_T_W-1:0]     t_word;

    assign pload_s = strobe_s[1];
    assign sload_s = strobe_s[0];
    assign m_pin_s = pins_s[SDC_M_W+SDC_N_W-1:SDC_N_W];
    assign n_pin_s = pins_s[SDC_N_W-1:0];
    assign t_word  = word_s[SDC_T_LSB +: SDC_T_W]; // R5
    assign n_word  = word_s[SDC_N_LSB +: SDC_N_W]; // R5
    assign m_word  = word_s[SDC_M_LSB +: SDC_M_W]; // R5 R10

    // Edge detection on synchronised strobes
    logic pload_d_r;
    logic sload_d_r;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pload_d_r <= 1'b0;
            sload_d_r <= 1'b0;
        end else begin
            pload_d_r <= pload_s;
            sload_d_r <= sload_s;
        end
    end

    logic pload_rise;
    logic sload_fall;
    logic serial_take;

    assign pload_rise  = pload_s & ~pload_d_r;
    assign sload_fall  = sload_d_r & ~sload_s; // R8
    // Parallel side has priority; serial transfer needs the strobe high
    assign serial_take = sload_fall & pload_s & pload_d_r; // R4 R7

    // Feedback and post divider settings
    logic [SDC_M_W-1:0] m_r;
    logic [SDC_N_W-1:0] n_r;
    logic [SDC_M_W-1:0] m_nxt;
    logic [SDC_N_W-1:0] n_nxt;

    always_comb begin
        m_nxt = m_r; // R18
        n_nxt = n_r; // R18
        if (!pload_s) begin
            m_nxt = m_pin_s; // R2
            n_nxt = n_pin_s; // R2
        end else if (pload_rise) begin
            m_nxt = m_pin_s; // R1
            n_nxt = n_pin_s; // R1
        end else if (serial_take) begin
            m_nxt = m_word; // R7 R10
            n_nxt = n_word; // R7
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            m_r <= SDC_M_RST;
            n_r <= SDC_N_RST;
        end else begin
            m_r <= m_nxt;
            n_r <= n_nxt;
        end
    end

    // Test select: only serially loadable, forced while parallel strobe is low
    logic [SDC_T_W-1:0] t_r;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            t_r <= SDC_T_RST;
        end else if (!pload_s) begin
            t_r <= SDC_T_FORCED; // R15
        end else if (serial_take) begin
            t_r <= t_word; // R5 R7
        end
    end

    // Load status
    logic update_r;
    logic src_serial_r;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            update_r     <= 1'b0;
            src_serial_r <= 1'b0;
        end else begin
            update_r <= pload_rise | serial_take;
            if (!pload_s || pload_rise) begin
                src_serial_r <= 1'b0;
            end else if (serial_take) begin
                src_serial_r <= 1'b1;
            end
        end
    end

    // Frequency status, one cycle behind the settings
    logic [SDC_FREQ_W-1:0] fout_r;
    logic [SDC_FREQ_W-1:0] fstep_r;
    logic [SDC_FREQ_W-1:0] vco_khz;
    logic                  vco_ok_r;
    logic [3:0]            ratio_r;

    assign vco_khz = SDC_FREQ_W'((XTAL_W * SDC_FREQ_W'(m_r)) / SDC_FREQ_W'(SDC_VCO_DIV));

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fout_r  <= '0;
            fstep_r <= '0;
            ratio_r <= 4'h1;
        end else begin
            fout_r  <= sdc_post_scale(SDC_FREQ_W'(REF_KHZ * SDC_FREQ_W'(m_r)), n_r); // R11 R12
            fstep_r <= sdc_post_scale(REF_KHZ, n_r); // R11
            ratio_r <= sdc_post_ratio(n_r); // R9
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            vco_ok_r <= 1'b0;
        end else begin
            vco_ok_r <= (vco_khz >= VCO_MIN) && (vco_khz <= VCO_MAX);
        end
    end

    // Outputs straight from flip-flops
    assign o_m_div        = m_r;
    assign o_n_sel        = n_r;
    assign o_test_sel     = t_r;
    assign o_post_ratio   = ratio_r;
    assign o_cfg_update   = update_r;
    assign o_src_serial   = src_serial_r;
    assign o_fout_khz     = fout_r;
    assign o_fstep_khz    = fstep_r;
    assign o_vco_in_range = vco_ok_r;
endmodule

// *** verilog/sdc_top_end.sv ***
// Holds no logic; the loader lives in the main design file

// *** sim/sdc_asserts.sv ***
// Concurrent checks on the ports of the divider configuration loader
`timescale 1ns/100ps
module sdc_asserts
    import sdc_pkg::*;
#(
    parameter int unsigned XTAL_KHZ = SDC_XTAL_KHZ
) (
    input wire logic                  i_clk,
    input wire logic                  i_rst_b,
    input wire logic                  i_pload_b,
    input wire logic [SDC_M_W-1:0]    i_m_pin,
    input wire logic [SDC_N_W-1:0]    i_n_pin,
    input wire logic                  i_sload,
    input wire logic [SDC_M_W-1:0]    o_m_div,
    input wire logic [SDC_N_W-1:0]    o_n_sel,
    input wire logic [3:0]            o_post_ratio,
    input wire logic [SDC_T_W-1:0]    o_test_sel,
    input wire logic                  o_cfg_update,
    input wire logic                  o_src_serial,
    input wire logic [SDC_FREQ_W-1:0] o_fout_khz,
    input wire logic [SDC_FREQ_W-1:0] o_fstep_khz
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_pins_follow: assert property (!i_pload_b [*5] |-> o_m_div == $past(i_m_pin, 3) && o_n_sel == $past(i_n_pin, 3))
        else $error("divider settings do not follow the pins");
    a_test_forced: assert property (!i_pload_b [*4] |-> o_test_sel == 3'h0)
        else $error("test select not forced to zero");
    a_settings_hold: assert property ((i_pload_b && !i_sload) [*6] |=> $stable({o_m_div, o_n_sel, o_test_sel}))
        else $error("divider settings changed without a load");
    a_serial_xfer: assert property ($fell(i_sload) && i_pload_b && $past(i_pload_b, 4) |-> ##[2:5] (o_cfg_update && o_src_serial))
        else $error("serial strobe fall did not transfer");
    a_no_rise_load: assert property ((i_sload && i_pload_b) [*6] |-> !o_cfg_update)
        else $error("transfer while serial strobe high");
    a_pload_capture: assert property ($rose(i_pload_b) |-> ##[2:5] (o_cfg_update && !o_src_serial))
        else $error("parallel strobe rise did not capture");
    a_post_ratio: assert property (o_post_ratio == 4'h1 << $past(o_n_sel))
        else $error("post divide ratio wrong");
    a_fout_calc: assert property ($past(i_rst_b) |-> o_fout_khz == (32'(XTAL_KHZ / SDC_REF_DIV) * 32'($past(o_m_div))) >> $past(o_n_sel))
        else $error("output frequency wrong");
    a_fstep_calc: assert property ($past(i_rst_b) |-> o_fstep_khz == 32'(XTAL_KHZ / SDC_REF_DIV) >> $past(o_n_sel))
        else $error("frequency step wrong");
endmodule
bind sdc_top sdc_asserts #(.XTAL_KHZ(XTAL_KHZ)) u_asserts (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_pload_b(i_pload_b),
    .i_m_pin(i_m_pin), .i_n_pin(i_n_pin), .i_sload(i_sload), .o_m_div(o_m_div), .o_n_sel(o_n_sel),
    .o_post_ratio(o_post_ratio), .o_test_sel(o_test_sel), .o_cfg_update(o_cfg_update),
    .o_src_serial(o_src_serial), .o_fout_khz(o_fout_khz), .o_fstep_khz(o_fstep_khz));

// *** sim/sdc_ctl_model.sv ***
// Board controller model driving the parallel and serial configuration pins
`timescale 1ns/100ps
module sdc_ctl_model
    import sdc_pkg::*;
(
    input  wire logic               i_clk,
    output logic                    o_pload_b,
    output logic [SDC_M_W-1:0]      o_m_pin,
    output logic [SDC_N_W-1:0]      o_n_pin,
    output logic                    o_sclk,
    output logic                    o_sdata,
    output logic                    o_sload
);
    initial begin
        o_pload_b = 1'b0;
        o_m_pin = 9'h0C8;
        o_n_pin = 2'h0;
        o_sclk = 1'b0;
        o_sdata = 1'b1;
        o_sload = 1'b0;
    end

    // Pins held 6 cycles either side of the strobe rise, then left at their inverse
    task automatic par_set(input logic [SDC_M_W-1:0] m, input logic [SDC_N_W-1:0] n, input logic cap);
        @(posedge i_clk);
        o_pload_b <= 1'b0;
        o_m_pin <= m;
        o_n_pin <= n;
        repeat (6) @(posedge i_clk);
        if (cap) begin
            o_pload_b <= 1'b1;
            repeat (6) @(posedge i_clk);
            o_m_pin <= ~m;
            o_n_pin <= ~n;
        end
    endtask

    // Leading junk bits are pushed out; shift clock idles low outside the frame
    task automatic ser_shift(input logic [SDC_SHIFT_W-1:0] w, input int junk);
        logic [SDC_SHIFT_W+3:0] s;
        s = {4'hF, w};
        @(posedge i_clk);
        #3;
        for (int i = SDC_SHIFT_W - 1 + junk; i >= 0; i--) begin
            o_sdata <= s[i];
            #40 o_sclk <= 1'b1;
            #40 o_sclk <= 1'b0;
        end
        o_sdata <= ~s[0];
    endtask

    // Six cycles keep each strobe level longer than the minimum pulse width
    task automatic sload_set(input logic v);
        repeat (6) @(posedge i_clk);
        o_sload <= v;
    endtask
endmodule

// *** sim/synth_divider_config_loader_bench.sv ***
// Self-checking bench for the divider configuration loader
`timescale 1ns/100ps
module synth_divider_config_loader_bench;
    import sdc_pkg::*;
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    logic                  pload_b, sclk, sdata, sload;
    logic [SDC_M_W-1:0]    m_pin, m_div;
    logic [SDC_N_W-1:0]    n_pin, n_sel;
    logic [3:0]            ratio;
    logic [SDC_T_W-1:0]    test_sel;
    logic                  cfg_upd, src_ser, vco_ok;
    logic [SDC_FREQ_W-1:0] fout, fstep;
    int                    n_mismatch = 0;
    int                    total_checks = 0;

    always #5 clk = ~clk;

    sdc_ctl_model ctl (.i_clk(clk), .o_pload_b(pload_b), .o_m_pin(m_pin), .o_n_pin(n_pin),
        .o_sclk(sclk), .o_sdata(sdata), .o_sload(sload));
    sdc_top uut (.i_clk(clk), .i_rst_b(rst_b), .i_pload_b(pload_b), .i_m_pin(m_pin), .i_n_pin(n_pin),
        .i_sclk(sclk), .i_sdata(sdata), .i_sload(sload), .o_m_div(m_div), .o_n_sel(n_sel),
        .o_post_ratio(ratio), .o_test_sel(test_sel), .o_cfg_update(cfg_upd), .o_src_serial(src_ser),
        .o_fout_khz(fout), .o_fstep_khz(fstep), .o_vco_in_range(vco_ok));

    task automatic close_out;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_cfg(input logic [SDC_M_W-1:0] m, input logic [SDC_N_W-1:0] n, input logic [SDC_T_W-1:0] t);
        #1;
        total_checks++;
        if ({m_div, n_sel, test_sel} !== {m, n, t}) begin
            n_mismatch++;
            $display("[FAIL] %0t settings %h %h %h", $time, m_div, n_sel, test_sel);
        end
    endtask

    task automatic chk_frq(input logic [SDC_M_W-1:0] m, input logic [SDC_N_W-1:0] n, input logic src);
        logic [SDC_FREQ_W-1:0] fo;
        logic                  v;
        #1;
        fo = (32'(SDC_XTAL_KHZ / SDC_REF_DIV) * 32'(m)) >> n;
        v = (SDC_XTAL_KHZ * m / SDC_VCO_DIV >= SDC_VCO_MIN_KHZ) && (SDC_XTAL_KHZ * m / SDC_VCO_DIV <= SDC_VCO_MAX_KHZ);
        total_checks++;
        if ({fout, fstep, ratio, vco_ok, src_ser} !==
            {fo, 32'(SDC_XTAL_KHZ / SDC_REF_DIV) >> n, 4'h1 << n, v, src}) begin
            n_mismatch++;
            $display("[FAIL] %0t frequency status %0d %0d %h", $time, fout, fstep, ratio);
        end
    endtask

    initial begin
        #50000;
        n_mismatch++;
        close_out;
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        chk_cfg(9'h000, 2'h0, 3'h0);
        repeat (4) @(posedge clk);
        ctl.par_set(9'h190, 2'h0, 1'b0);
        chk_cfg(9'h190, 2'h0, 3'h0);
        chk_frq(9'h190, 2'h0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            ctl.par_set(9'h0C8, 2'(k), 1'b0);
            chk_frq(9'h0C8, 2'(k), 1'b0);
        end
        ctl.par_set(9'h106, 2'h1, 1'b1);
        chk_cfg(9'h106, 2'h1, 3'h0);
        chk_frq(9'h106, 2'h1, 1'b0);
        ctl.ser_shift({3'h5, 2'h3, 9'h12C}, 2);
        ctl.sload_set(1'b1);
        repeat (6) @(posedge clk);
        chk_cfg(9'h106, 2'h1, 3'h0);
        ctl.sload_set(1'b0);
        repeat (6) @(posedge clk);
        chk_cfg(9'h12C, 2'h3, 3'h5);
        chk_frq(9'h12C, 2'h3, 1'b1);
        ctl.par_set(9'h1F4, 2'h0, 1'b0);
        chk_cfg(9'h1F4, 2'h0, 3'h0);
        chk_frq(9'h1F4, 2'h0, 1'b0);
        ctl.ser_shift({3'h7, 2'h2, 9'h150}, 0);
        ctl.sload_set(1'b1);
        ctl.sload_set(1'b0);
        repeat (6) @(posedge clk);
        chk_cfg(9'h1F4, 2'h0, 3'h0);
        chk_frq(9'h1F4, 2'h0, 1'b0);
        close_out;
    end
endmodule
